// ==== srmc_pkg.sv ====
package srmc_pkg;
	localparam int ADDR_W = 16;
	localparam int CLK_PERIOD_NS = 20;
	// Least times on the memory pins, in ns
	localparam int T_RC_NS = 12;
	localparam int T_WC_NS = 12;
	localparam int T_WP_NS = 10;
	localparam int T_CW_NS = 11;
	localparam int T_AW_NS = 11;
	localparam int T_DW_NS = 7;
	localparam int T_AA_NS = 12;
	localparam int T_HZ_NS = 7;
	// Least times round up to whole cycles, never below one
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RD_CYC = cyc_min(T_AA_NS) + 1;
	localparam int WP_CYC = cyc_min(T_WP_NS > T_CW_NS ? T_WP_NS : T_CW_NS);
	localparam int HZ_CYC = cyc_min(T_HZ_NS);
	localparam logic [3:0] CNT_ONE = 4'h1;
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic wdata;
	} srmc_req_t;
	typedef struct packed {
		logic [ADDR_W-1:0] word_index;
		logic din;
		logic cs_n;
		logic we_n;
	} srmc_pins_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_ACCESS = 3'h3,
		ST_DONE = 3'h2,
		ST_GAP = 3'h6
	} srmc_state_t;
endpackage

// ==== srmc_delay.sv ====
`timescale 1ns/1ps
module srmc_delay
	import srmc_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst, // Sync reset
	input wire logic load, // Start count
	input wire logic [3:0] len, // Cycles to count
	output logic done // High on last cycle
);
	logic [3:0] cnt;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 4'h0;
		end else if (load) begin
			cnt <= len;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - CNT_ONE;
		end
	end
	assign done = (cnt == CNT_ONE) && !load;
endmodule

// ==== srmc_ctrl.sv ====
// Behaviour
// - Controller keeps every read cycle at least 12 ns long.
// - Select and write enable low store the bit; output floats within 7 ns.
// - Address valid 11 ns before write end; write pulse at least 10 ns.
// - Chip select held low 11 ns before write end.
// - Write data stable 7 ns before write end, held 0 ns after.
`timescale 1ns/1ps
module srmc_ctrl
	import srmc_pkg::*;
(
	input wire logic CLK_SYS, // 50 MHz clock
	input wire logic SYS_RST, // Sync reset, active high
	input wire logic REQ_VALID, // Request present
	output logic REQ_READY, // Request taken when valid
	input wire srmc_req_t REQ, // Request word
	output logic RSP_VALID, // One-cycle read answer
	output logic RSP_DATA, // Read bit
	output srmc_pins_t MEM, // Memory pins
	input wire logic MEM_DOUT // Memory data output pin
);
	srmc_state_t state;
	srmc_req_t cur;
	logic dout_s1, dout_s2;
	logic cnt_load, cnt_done;
	logic [3:0] cnt_len;

	assign REQ_READY = (state == ST_IDLE);

	// Two flops on the memory output pin; the second one alone is read
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			dout_s1 <= 1'b0;
			dout_s2 <= 1'b0;
		end else begin
			dout_s1 <= MEM_DOUT;
			dout_s2 <= dout_s1;
		end
	end

	always_comb begin
		cnt_load = 1'b0;
		cnt_len = 4'h0;
		if (state == ST_SETUP) begin
			cnt_load = 1'b1;
			cnt_len = cur.write ? 4'(WP_CYC) : 4'(RD_CYC + 2);
		end else if (state == ST_DONE) begin
			cnt_load = 1'b1;
			cnt_len = 4'(HZ_CYC);
		end
	end

	srmc_delay u_delay (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.load(cnt_load),
		.len(cnt_len),
		.done(cnt_done)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			state <= ST_IDLE;
			cur <= '0;
		end else begin
			unique case (state)
				ST_IDLE: if (REQ_VALID) begin
					cur <= REQ;
					state <= ST_SETUP;
				end
				ST_SETUP: state <= ST_ACCESS;
				ST_ACCESS: if (cnt_done) begin
					state <= ST_DONE;
				end
				ST_DONE: state <= ST_GAP;
				ST_GAP: if (cnt_done) begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Pins: address and data set a cycle before strobes, held a cycle after
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			MEM <= '{word_index: '0, din: 1'b0, cs_n: 1'b1, we_n: 1'b1};
		end else begin
			if (state == ST_IDLE && REQ_VALID) begin
				MEM.word_index <= REQ.addr;
				MEM.din <= REQ.wdata;
			end
			MEM.cs_n <= !(state == ST_SETUP || (state == ST_ACCESS && !cnt_done));
			MEM.we_n <= !(cur.write && (state == ST_SETUP
				|| (state == ST_ACCESS && !cnt_done)));
		end
	end

	// Sample the bit late in the access, after the sync delay
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			RSP_VALID <= 1'b0;
			RSP_DATA <= 1'b0;
		end else begin
			RSP_VALID <= (state == ST_ACCESS) && cnt_done && !cur.write;
			if ((state == ST_ACCESS) && cnt_done && !cur.write) begin
				RSP_DATA <= dout_s2;
			end
		end
	end

	property p_addr_stable;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		!MEM.cs_n && !$past(MEM.cs_n) |-> $stable(MEM.word_index);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved in access");

	// Cycles spent with each strobe low, judged when the strobe returns high
	localparam int WC_CYC = cyc_min(T_WC_NS);
	logic [3:0] we_low_cnt;
	logic [3:0] cs_low_cnt;
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			we_low_cnt <= 4'h0;
		end else if (!MEM.we_n) begin
			we_low_cnt <= we_low_cnt + CNT_ONE;
		end else begin
			we_low_cnt <= 4'h0;
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			cs_low_cnt <= 4'h0;
		end else if (!MEM.cs_n) begin
			cs_low_cnt <= cs_low_cnt + CNT_ONE;
		end else begin
			cs_low_cnt <= 4'h0;
		end
	end

	sequence s_wr_start;
		$fell(MEM.we_n);
	endsequence
	sequence s_wr_end;
		$rose(MEM.we_n);
	endsequence
	property p_wp_width;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_wr_end |-> we_low_cnt >= 4'(WP_CYC);
	endproperty
	a_wp_width: assert property (p_wp_width) else $error("write pulse too short");

	property p_we_in_cs;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		!MEM.we_n |-> !MEM.cs_n;
	endproperty
	a_we_in_cs: assert property (p_we_in_cs) else $error("write without select");

	property p_din_stable;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		!MEM.we_n |-> $stable(MEM.din) ##1 $stable(MEM.din);
	endproperty
	a_din_stable: assert property (p_din_stable) else $error("write data moved");

	property p_read_len;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$fell(MEM.cs_n) && MEM.we_n |-> !MEM.cs_n [*4] ##1 MEM.cs_n;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read cycle too short");

	property p_rsp_pulse;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		RSP_VALID |=> !RSP_VALID;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than a cycle");

	property p_gap;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$rose(MEM.cs_n) |-> MEM.cs_n [*4];
	endproperty
	a_gap: assert property (p_gap) else $error("no deselect gap");

	property p_done_bound;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$fell(MEM.cs_n) |-> ##[1:12] MEM.cs_n;
	endproperty
	a_done_bound: assert property (p_done_bound) else $error("access never ended");

	property p_wr_setup;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_wr_start |-> $stable(MEM.word_index) && $stable(MEM.din);
	endproperty
	a_wr_setup: assert property (p_wr_setup) else $error("address or data late for write");

	property p_rd_cycle;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$rose(MEM.cs_n) && $past(MEM.we_n) |-> cs_low_cnt == 4'(RD_CYC + 2);
	endproperty
	a_rd_cycle: assert property (p_rd_cycle) else $error("read select length wrong");

	property p_wc_len;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$rose(MEM.cs_n) && !$past(MEM.we_n) |-> cs_low_cnt >= 4'(WC_CYC);
	endproperty
	a_wc_len: assert property (p_wc_len) else $error("write cycle too short");

	property p_rsp_lat;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$fell(MEM.cs_n) && MEM.we_n |-> ##4 RSP_VALID;
	endproperty
	a_rsp_lat: assert property (p_rsp_lat) else $error("read answer not on time");

	property p_busy;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		!MEM.cs_n |-> !REQ_READY;
	endproperty
	a_busy: assert property (p_busy) else $error("request taken during access");

	property p_no_wr_rsp;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		$rose(MEM.cs_n) && !$past(MEM.we_n) |-> !RSP_VALID;
	endproperty
	a_no_wr_rsp: assert property (p_no_wr_rsp) else $error("answer after a write");
endmodule

// ==== srmc_sram_model.sv ====
`timescale 1ns/1ps
module srmc_sram_model
	import srmc_pkg::*;
(
	input wire srmc_pins_t MEM, // Pins from the controller
	output logic dout // Data out, inverted last bit while floating
);
	logic mem [0:65535];
	logic last = 1'b0;
	wire rd = ~MEM.cs_n & MEM.we_n;
	wire wr = ~MEM.cs_n & ~MEM.we_n;
	initial for (int i = 0; i < 65536; i++) mem[i] = 1'b0;
	// Store at the end of the write, when the first of the two strobes rises
	always @(negedge wr) mem[MEM.word_index] = MEM.din;
	always @(rd or MEM.word_index) begin
		if (rd) begin
			last = mem[MEM.word_index];
			dout <= #10 last;
		end else begin
			dout <= #5 ~last;
		end
	end
endmodule

// ==== srmc_ctrl_bench.sv ====
`timescale 1ns/1ps
module srmc_ctrl_bench;
	import srmc_pkg::*;
	logic CLK_SYS = 1'b0;
	logic SYS_RST = 1'b1;
	logic REQ_VALID = 1'b0;
	srmc_req_t REQ = '0;
	logic REQ_READY, RSP_VALID, RSP_DATA, MEM_DOUT;
	srmc_pins_t MEM;
	int num_errors = 0;
	int compares = 0;
	always #10 CLK_SYS = ~CLK_SYS;
	srmc_ctrl i_srmc_ctrl (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID),
		.REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
		.MEM(MEM), .MEM_DOUT(MEM_DOUT));
	srmc_sram_model i_srmc_sram_model (.MEM(MEM), .dout(MEM_DOUT));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (num_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// One request, then watch the strobes until they rise again
	task automatic op(input logic w, input logic [15:0] a, input logic d);
		int n;
		int lo;
		int wlo;
		n = 0;
		lo = 0;
		wlo = 0;
		@(posedge CLK_SYS);
		#1;
		REQ = '{write: w, addr: a, wdata: d};
		REQ_VALID = 1'b1;
		do begin
			@(negedge CLK_SYS);
			n++;
		end while (REQ_READY !== 1'b1 && n < 50);
		chk(REQ_READY, 1'b1);
		@(posedge CLK_SYS);
		#1;
		REQ_VALID = 1'b0;
		n = 0;
		do begin
			@(negedge CLK_SYS);
			n++;
			if (n == 1) chk(REQ_READY, 1'b0);
			if (MEM.cs_n === 1'b0) begin
				lo++;
				chk(MEM.word_index, a);
				if (w) chk(MEM.din, d);
			end
			if (MEM.we_n === 1'b0) wlo++;
		end while (!(lo > 0 && MEM.cs_n === 1'b1) && n < 50);
		chk(RSP_VALID, !w);
		if (!w) chk(RSP_DATA, d);
		chk(lo, w ? WP_CYC : RD_CYC + 2);
		chk(wlo, w ? WP_CYC : 0);
	endtask
	task automatic t_idle();
		repeat (4) @(negedge CLK_SYS);
		chk({MEM.cs_n, MEM.we_n, REQ_READY, RSP_VALID}, 4'hE);
	endtask
	// Corner addresses with MSB and LSB aliases of opposite value catch aliasing; 7FFF and 8000 both hold 0
	task automatic t_corners();
		logic [15:0] a [5] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF, 16'h0001};
		logic [4:0] d = 5'h05;
		for (int i = 0; i < 5; i++) op(1'b1, a[i], d[i]);
		for (int i = 0; i < 5; i++) op(1'b0, a[i], d[i]);
	endtask
	task automatic t_overwrite();
		op(1'b1, 16'h1234, 1'b1);
		op(1'b0, 16'h1234, 1'b1);
		op(1'b1, 16'h1234, 1'b0);
		op(1'b1, 16'h1235, 1'b1);
		op(1'b0, 16'h1234, 1'b0);
		op(1'b0, 16'h1235, 1'b1);
	endtask
	initial begin
		repeat (12) @(posedge CLK_SYS);
		#1;
		SYS_RST = 1'b0;
		@(negedge CLK_SYS);
		t_idle();
		t_corners();
		t_overwrite();
		t_idle();
		end_sim();
	end
	initial begin
		#(CLK_PERIOD_NS * 2000);
		num_errors++;
		end_sim();
	end
endmodule
